//--- fcs_flash_host.sv
// apb-controlled host that drives command sequences into a parallel flash
`timescale 1ns/1ps
module fcs_flash_host
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_STEP = 3'b001,
    SQ_WAIT = 3'b010,
    SQ_PWAIT = 3'b011,
    SQ_RWAIT = 3'b100
  } fcs_sq_t;

  typedef enum logic [1:0] {
    PH_FIRST = 2'b00,
    PH_CONFIRM = 2'b01,
    PH_RECHECK = 2'b10
  } fcs_ph_t;

  // number of bus cycles issued for each operation
  function automatic logic [2:0] op_len(input fcs_op_t op);
    unique case (op)
      OP_RESET3, OP_IDENT: op_len = (op == OP_IDENT) ? 3'd4 : 3'd3;
      OP_PROGRAM: op_len = 3'd4;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: op_len = 3'd6;
      OP_POLL: op_len = 3'd0;
      default: op_len = 3'd1;
    endcase
  endfunction

  // bus cycle number idx of operation op
  function automatic fcs_cycle_t op_cycle(input fcs_op_t op,
                                          input logic [2:0] idx,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [DATA_W-1:0] d);
    fcs_cycle_t c;
    c = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
    if (idx == 3'd1 || idx == 3'd4) begin
      c.addr = UNLOCK2_ADDR;
      c.data = UNLOCK2_DATA;
    end
    unique case (op)
      OP_RESET: c.data = CMD_RESET;
      OP_RESET3: if (idx == 3'd2) c.data = CMD_RESET;
      OP_IDENT: begin
        // two unlock writes and the ident command, then a code read at any offset
        if (idx == 3'd2) c.data = CMD_IDENT;
        if (idx == 3'd3) c = '{wr: 1'b0, addr: a, data: '0};
      end
      OP_READ: c = '{wr: 1'b0, addr: a, data: '0};
      OP_PROGRAM: begin
        if (idx == 3'd2) c.data = CMD_PROGRAM;
        if (idx == 3'd3) c = '{wr: 1'b1, addr: a, data: d};
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        if (idx == 3'd2) c.data = CMD_ERASE_SETUP;
        if (idx == 3'd5) begin
          c.data = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
          if (op == OP_SECTOR_ERASE) c.addr = a;
        end
      end
      // extra sector inside the open window
      OP_ADD_SECTOR: c = '{wr: 1'b1, addr: a, data: CMD_SECTOR_ERASE};
      OP_SUSPEND: c.data = CMD_SUSPEND;
      OP_RESUME: c.data = CMD_RESUME;
      OP_WRITE: c = '{wr: 1'b1, addr: a, data: d};
      default: c = '{wr: 1'b0, addr: a, data: '0};
    endcase
    return c;
  endfunction

  fcs_sq_t state, next_state;
  fcs_ph_t phase, next_phase;
  fcs_op_t op, next_op;
  logic [2:0] step, next_step;
  logic autopoll, next_autopoll;
  logic [ADDR_W-1:0] addr_reg, next_addr_reg;
  logic [DATA_W-1:0] data_reg, next_data_reg;
  logic [DATA_W-1:0] rd_data, next_rd_data;
  logic done, next_done;
  logic fail, next_fail;
  logic req_valid, next_req_valid;
  fcs_cycle_t req, next_req;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic req_ready, rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  logic setup_ph, apb_wr, mapped, busy, poll_ok, want_poll, expect_bit;

  fcs_bus_cycle u_cycle (
    .clk(clk),
    .srst(srst),
    .req_valid(req_valid),
    .req(req),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );

  assign busy = (state != SQ_IDLE);
  assign setup_ph = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) ||
                  (paddr == REG_DATA) || (paddr == REG_STAT);
  // erase completes with poll bit 1, program with the true bit 7
  assign expect_bit = (op == OP_PROGRAM || op == OP_POLL) ?
                      data_reg[POLL_BIT] : 1'b1;
  assign poll_ok = (rsp_data[POLL_BIT] == expect_bit);
  assign want_poll = (op == OP_POLL) || (autopoll &&
                     (op == OP_PROGRAM || op == OP_CHIP_ERASE ||
                      op == OP_SECTOR_ERASE));

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_op = op;
    next_step = step;
    next_autopoll = autopoll;
    next_addr_reg = addr_reg;
    next_data_reg = data_reg;
    next_rd_data = rd_data;
    next_done = done;
    next_fail = fail;
    next_req_valid = req_valid;
    next_req = req;
    next_pready = setup_ph;
    next_pslverr = setup_ph && !mapped;
    next_prdata = '0;
    if (setup_ph && !pwrite) begin
      unique case (paddr)
        REG_CTRL: next_prdata[CTRL_POLL] = autopoll;
        REG_ADDR: next_prdata[ADDR_W-1:0] = addr_reg;
        REG_DATA: next_prdata[DATA_W-1:0] = data_reg;
        REG_STAT: begin
          next_prdata[STAT_BUSY] = busy;
          next_prdata[STAT_DONE] = done;
          next_prdata[STAT_FAIL] = fail;
          next_prdata[STAT_RD_LSB +: DATA_W] = rd_data;
          next_prdata[STAT_STEP_LSB +: 3] = step;
        end
        default: next_prdata = '0;
      endcase
    end
    // software writes; operands and start are refused while busy
    if (apb_wr && !busy) begin
      unique case (paddr)
        REG_ADDR: next_addr_reg = pwdata[ADDR_W-1:0];
        REG_DATA: next_data_reg = pwdata[DATA_W-1:0];
        REG_CTRL: begin
          next_autopoll = pwdata[CTRL_POLL];
          next_done = 1'b0;
          next_fail = 1'b0;
          next_step = '0;
          next_phase = PH_FIRST;
          if (pwdata[CTRL_OP_LSB +: 4] > OP_WRITE) begin
            next_done = 1'b1;
            next_fail = 1'b1;
          end else begin
            next_op = fcs_op_t'(pwdata[CTRL_OP_LSB +: 4]);
            next_state = SQ_STEP;
          end
        end
        default: ;
      endcase
    end
    if (apb_wr && paddr == REG_STAT) begin
      if (pwdata[STAT_DONE]) next_done = 1'b0;
      if (pwdata[STAT_FAIL]) next_fail = 1'b0;
    end
    if (req_valid && req_ready) begin
      next_req_valid = 1'b0;
    end
    unique case (state)
      SQ_IDLE: ;
      SQ_STEP: begin
        if (step < op_len(op)) begin
          next_req = op_cycle(op, step, addr_reg, data_reg);
          next_req_valid = 1'b1;
          next_state = SQ_WAIT;
        end else if (want_poll) begin
          // first status read follows the last write's strobe
          next_req = '{wr: 1'b0, addr: addr_reg, data: '0};
          next_req_valid = 1'b1;
          next_phase = PH_FIRST;
          next_state = SQ_PWAIT;
        end else begin
          next_done = 1'b1;
          next_state = SQ_IDLE;
        end
      end
      SQ_WAIT: begin
        if (rsp_valid) begin
          next_rd_data = rsp_data;
          next_step = step + 3'd1;
          next_state = SQ_STEP;
        end
      end
      SQ_PWAIT: begin
        if (rsp_valid) begin
          next_rd_data = rsp_data;
          next_req = '{wr: 1'b0, addr: addr_reg, data: '0};
          next_req_valid = 1'b1;
          unique case (phase)
            PH_FIRST: begin
              if (poll_ok) begin
                next_phase = PH_CONFIRM;
              end else if (rsp_data[TIMEOUT_FAIL_BIT]) begin
                // poll bit may settle together with the fail bit
                next_phase = PH_RECHECK;
              end
            end
            PH_CONFIRM: begin
              // data is taken from the read after the poll bit turned
              next_req_valid = 1'b0;
              next_done = 1'b1;
              next_state = SQ_IDLE;
            end
            PH_RECHECK: begin
              if (poll_ok) begin
                next_phase = PH_CONFIRM;
              end else begin
                // failed operation needs a reset to read the array again
                next_req = '{wr: 1'b1, addr: addr_reg, data: CMD_RESET};
                next_fail = 1'b1;
                next_state = SQ_RWAIT;
              end
            end
            default: begin
              next_phase = PH_FIRST;
            end
          endcase
        end
      end
      SQ_RWAIT: begin
        if (rsp_valid) begin
          next_done = 1'b1;
          next_state = SQ_IDLE;
        end
      end
      default: begin
        next_state = SQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SQ_IDLE;
      phase <= PH_FIRST;
      op <= OP_RESET;
      step <= '0;
      autopoll <= 1'b0;
      addr_reg <= '0;
      data_reg <= '0;
      rd_data <= '0;
      done <= 1'b0;
      fail <= 1'b0;
      req_valid <= 1'b0;
      req <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      op <= next_op;
      step <= next_step;
      autopoll <= next_autopoll;
      addr_reg <= next_addr_reg;
      data_reg <= next_data_reg;
      rd_data <= next_rd_data;
      done <= next_done;
      fail <= next_fail;
      req_valid <= next_req_valid;
      req <= next_req;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule

//--- fcs_pkg.sv
// shared constants, command codes and carrier types of the flash host
package fcs_pkg;
  localparam int CLK_MHZ = 40;
  localparam int NS_PER_US = 1000;
  // bus cycle timing of the flash pins, in nanoseconds
  localparam int T_WP_NS = 50;
  localparam int T_RD_NS = 100;
  localparam int T_GAP_NS = 50;
  localparam int SYNC_STAGES = 2;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int RD_CYC = (T_RD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US
                          + SYNC_STAGES;
  localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int CNT_W = 8;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int SECTOR_LSB = 14;

  // register offsets on the apb side
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_POLL = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_RD_LSB = 8;
  localparam int STAT_STEP_LSB = 16;

  // flash command set
  localparam logic [16:0] UNLOCK1_ADDR = 17'h00555;
  localparam logic [16:0] UNLOCK2_ADDR = 17'h002AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_FAIL_BIT = 5;
  localparam int ERASE_WINDOW_BIT = 3;

  typedef enum logic [3:0] {
    OP_RESET = 4'h0,
    OP_RESET3 = 4'h1,
    OP_IDENT = 4'h2,
    OP_READ = 4'h3,
    OP_PROGRAM = 4'h4,
    OP_CHIP_ERASE = 4'h5,
    OP_SECTOR_ERASE = 4'h6,
    OP_ADD_SECTOR = 4'h7,
    OP_SUSPEND = 4'h8,
    OP_RESUME = 4'h9,
    OP_POLL = 4'hA,
    OP_WRITE = 4'hB
  } fcs_op_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_cycle_t;
endpackage

//--- fcs_bus_cycle.sv
// one read or write cycle on the flash pins
`timescale 1ns/1ps
module fcs_bus_cycle
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire fcs_cycle_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  typedef enum logic [2:0] {
    CY_IDLE = 3'b000,
    CY_SETUP = 3'b001,
    CY_STROBE = 3'b010,
    CY_HOLD = 3'b011,
    CY_GAP = 3'b100
  } fcs_cy_t;

  fcs_cy_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic wr, next_wr;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_data;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [DATA_W-1:0] next_flash_dq_out;
  logic next_flash_dq_oe_n, next_flash_ce_n, next_flash_we_n, next_flash_oe_n;
  logic [DATA_W-1:0] dq_meta, dq_sync;

  assign req_ready = (state == CY_IDLE);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_flash_addr = flash_addr;
    next_flash_dq_out = flash_dq_out;
    next_flash_dq_oe_n = flash_dq_oe_n;
    next_flash_ce_n = flash_ce_n;
    next_flash_we_n = flash_we_n;
    next_flash_oe_n = flash_oe_n;
    unique case (state)
      CY_IDLE: begin
        if (req_valid) begin
          // address and data settle before either strobe falls
          next_wr = req.wr;
          next_flash_addr = req.addr;
          next_flash_ce_n = 1'b0;
          next_flash_dq_out = req.data;
          next_flash_dq_oe_n = ~req.wr;
          next_state = CY_SETUP;
        end
      end
      CY_SETUP: begin
        // we falls after ce: address taken at this later edge
        next_flash_we_n = ~wr;
        next_flash_oe_n = wr;
        next_cnt = wr ? CNT_W'(WP_CYC - 1) : CNT_W'(RD_CYC - 1);
        next_state = CY_STROBE;
      end
      CY_STROBE: begin
        if (cnt == '0) begin
          if (!wr) begin
            next_rsp_data = dq_sync;
          end
          next_rsp_valid = 1'b1;
          // we rises while ce and data still held
          next_flash_we_n = 1'b1;
          next_flash_oe_n = 1'b1;
          next_state = CY_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      CY_HOLD: begin
        next_flash_ce_n = 1'b1;
        next_flash_dq_oe_n = 1'b1;
        next_cnt = CNT_W'(GAP_CYC - 1);
        next_state = CY_GAP;
      end
      CY_GAP: begin
        if (cnt == '0) begin
          next_state = CY_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    dq_meta <= flash_dq_in;
    dq_sync <= dq_meta;
    if (srst) begin
      state <= CY_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      flash_addr <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      flash_addr <= next_flash_addr;
      flash_dq_out <= next_flash_dq_out;
      flash_dq_oe_n <= next_flash_dq_oe_n;
      flash_ce_n <= next_flash_ce_n;
      flash_we_n <= next_flash_we_n;
      flash_oe_n <= next_flash_oe_n;
    end
  end
endmodule

//--- fcs_flash_host_checker.sv
// concurrent checks on the apb and flash pins of the flash host
`timescale 1ns/1ps
module fcs_flash_host_checker
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic [DATA_W-1:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_ready_setup:
    assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_cause:
    assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_err_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_idle_rdata:
    assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  a_unmapped_err:
    assert property (psel && !penable && paddr > REG_STAT |=> pslverr)
    else $error("unmapped access without pslverr");
  a_we_qualified:
    assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n &&
                     flash_oe_n)
    else $error("write strobe without select or data drive");
  a_we_width:
    assert property ($fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n)
    else $error("write strobe width wrong");
  a_we_hold:
    assert property (!flash_we_n |-> $stable(flash_addr) &&
                     $stable(flash_dq_out))
    else $error("address or data moved under write strobe");
  a_we_release:
    assert property ($rose(flash_we_n) |-> $stable(flash_dq_out)
                     ##1 flash_ce_n && flash_dq_oe_n)
    else $error("write cycle not closed after strobe rise");
  a_oe_width:
    assert property ($fell(flash_oe_n) |-> !flash_oe_n [*6] ##1 flash_oe_n)
    else $error("read strobe width wrong");
  a_read_release:
    assert property (!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n)
    else $error("data driven during read");
endmodule

bind fcs_flash_host fcs_flash_host_checker chk_u (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
);

//--- fcs_flash_model.sv
// behavioural parallel flash device facing the host
`timescale 1ns/1ps
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'hC3, // arbitrary value
  parameter int BUSY_RD = 3,
  parameter logic [7:0] PROT = 8'h00
)
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [DATA_W-1:0] dq_in
);
  // mode 0 array, 1 ident, 2 program, 3 sector erase, 4 chip erase
  logic [7:0] mem [int];
  logic [7:0] secm = 8'h00;
  logic [7:0] pd = 8'h00;
  logic [7:0] rv = 8'h00;
  logic [7:0] last = 8'h00;
  logic [16:0] pa;
  logic [16:0] al;
  logic susp = 1'b0;
  logic fl = 1'b0;
  logic tog = 1'b0;
  int mode = 0;
  int seq = 0;
  int cnt = 0;
  wire wr_n = ce_n | we_n;
  wire rd_n = ce_n | oe_n;
  function automatic logic [7:0] arr(input logic [16:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction
  always @(negedge wr_n) al = addr;
  always @(posedge wr_n) begin
    if (mode == 3 && dq_out == CMD_SUSPEND) begin
      mode = 0;
      susp = 1'b1;
    end else if (mode == 3 && dq_out == CMD_SECTOR_ERASE) begin
      secm[al[16:14]] = 1'b1;
      cnt = BUSY_RD;
    end else if (fl && dq_out == CMD_RESET) begin
      mode = 0;
      fl = 1'b0;
    end else if (mode >= 2) begin
      seq = 0;
    end else if (susp && seq == 0 && dq_out == CMD_RESUME) begin
      mode = 3;
      susp = 1'b0;
      cnt = BUSY_RD;
    end else if (dq_out == CMD_RESET && (seq == 0 || seq == 2)) begin
      mode = 0;
      seq = 0;
    end else if ((seq == 0 || seq == 4) && dq_out == UNLOCK1_DATA &&
                 al == UNLOCK1_ADDR) seq++;
    else if ((seq == 1 || seq == 5) && dq_out == UNLOCK2_DATA &&
             al == UNLOCK2_ADDR) seq++;
    else if (seq == 2 && al == UNLOCK1_ADDR && dq_out == CMD_IDENT) begin
      mode = 1;
      seq = 0;
    end else if (seq == 2 && al == UNLOCK1_ADDR && dq_out == CMD_PROGRAM) seq = 3;
    else if (seq == 2 && al == UNLOCK1_ADDR && dq_out == CMD_ERASE_SETUP)
      seq = 4;
    else if (seq == 3) begin
      pa = al;
      pd = dq_out;
      mode = 2;
      cnt = BUSY_RD;
      seq = 0;
    end else if (seq == 6 && dq_out == CMD_CHIP_ERASE) begin
      mode = 4;
      cnt = BUSY_RD;
      seq = 0;
    end else if (seq == 6 && dq_out == CMD_SECTOR_ERASE) begin
      secm = 8'h00;
      secm[al[16:14]] = 1'b1;
      mode = 3;
      cnt = BUSY_RD;
      seq = 0;
    end else seq = 0;
  end
  always @(negedge rd_n) begin
    if (mode == 1)
      rv = addr[7:0] == 8'h00 ? MAKER_CODE :
           addr[7:0] == 8'h01 ? PART_CODE : {7'h00, PROT[addr[16:14]]};
    else if (mode == 2)
      rv = {~pd[7], tog, fl, 5'h00};
    else if (mode >= 3)
      rv = {1'b0, tog, 2'b00, 1'b1, 3'b000};
    else if (susp && secm[addr[16:14]])
      rv = 8'h80;
    else
      rv = arr(addr);
  end
  // released lines show the inverse of the last value read
  assign dq_in = rd_n ? ~last : rv;
  always @(posedge rd_n) begin
    last = rv;
    if (mode >= 2) begin
      tog = ~tog;
      cnt--;
    end
    if (mode == 2 && cnt == 0 && !PROT[pa[16:14]] && (pd & ~arr(pa)) != 0)
      fl = 1'b1;
    else if (mode >= 2 && cnt == 0) begin
      if (mode == 2 && !PROT[pa[16:14]])
        mem[int'(pa)] = arr(pa) & pd;
      if (mode == 4) mem.delete();
      if (mode == 3) foreach (mem[k]) if (secm[k[16:14]]) mem[k] = 8'hFF;
      if (mode != 2) secm = 8'h00;
      mode = 0;
    end
  end
endmodule

//--- fcs_flash_host_tb.sv
// self-checking bench for the flash host with a flash device model
`timescale 1ns/1ps
module fcs_flash_host_tb
  import fcs_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] PART = 8'hC3; // arbitrary value
  logic clk, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [ADDR_W-1:0] flash_addr, ta;
  logic [DATA_W-1:0] flash_dq_out, flash_dq_in, td;
  logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic [7:0] rm [int];
  int error_cnt = 0;
  int tests_run = 0;
  fcs_flash_host dut_u (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
  fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART),
    .PROT(8'h80)) dev_u (
    .addr(flash_addr), .dq_out(flash_dq_out), .dq_oe_n(flash_dq_oe_n),
    .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
    .dq_in(flash_dq_in));
  function automatic logic [7:0] ref_rd(input logic [16:0] a);
    return rm.exists(int'(a)) ? rm[int'(a)] : 8'hFF;
  endfunction
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [3:0] c, input logic [16:0] a,
                    input logic [7:0] d, input logic ap, output logic [31:0] s);
    int n;
    logic er;
    apb(1'b1, REG_ADDR, {15'h0, a}, s, er);
    apb(1'b1, REG_DATA, {24'h0, d}, s, er);
    apb(1'b1, REG_CTRL, {23'h0, ap, 4'h0, c}, s, er);
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0, s, er);
      n++;
    end while (s[STAT_DONE] !== 1'b1 && n < 3000);
    if (s[STAT_DONE] !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] op done expected 1 seen %b", s[STAT_DONE]);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2000000;
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    close_out();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(15792));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h10, 32'h0, st, e);
    chk("unmapped err", 8'h01, {7'h00, e});
    chk("unmapped data", 8'h00, st[7:0]);
    for (int i = 0; i < 3; i++) begin
      op(OP_IDENT, i == 2 ? 17'h04002 : 17'(i), 8'h00, 1'b0, st);
      chk("ident", i == 0 ? MAKER : i == 1 ? PART : 8'h00,
          st[15:8]);
      op(i == 1 ? OP_RESET3 : OP_RESET, 17'h0, 8'h00, 1'b0, st);
      op(OP_READ, 17'h0, 8'h00, 1'b0, st);
      chk("array after reset", 8'hFF, st[15:8]);
    end
    op(OP_IDENT, 17'h1C002, 8'h00, 1'b0, st);
    chk("protected", 8'h01, st[15:8]);
    op(OP_RESET, 17'h0, 8'h00, 1'b0, st);
    op(OP_PROGRAM, 17'h1C000, 8'h80, 1'b1, st);
    chk("prot prog", 8'hFF, st[15:8]);
    for (int i = 0; i < 4; i++) begin
      ta = {3'd2, 14'(i * 64) | 14'($urandom_range(0, 63))};
      td = 8'($urandom);
      rm[int'(ta)] = td;
      op(OP_PROGRAM, ta, td, 1'b1, st);
      chk("prog status", 8'h02, {5'h00, st[2:0]});
      chk("prog poll byte", td, st[15:8]);
      op(OP_READ, ta, 8'h00, 1'b0, st);
      chk("prog readback", ref_rd(ta), st[15:8]);
    end
    rm[32'h4010] = 8'h00;
    op(OP_PROGRAM, 17'h04010, 8'h00, 1'b1, st);
    op(OP_SECTOR_ERASE, 17'h04000, 8'h00, 1'b0, st);
    op(OP_ADD_SECTOR, 17'h0C000, 8'h00, 1'b0, st);
    op(OP_SUSPEND, 17'h0, 8'h00, 1'b0, st);
    op(OP_READ, 17'h0C000, 8'h00, 1'b0, st);
    chk("suspended sector", 8'h80, st[15:8]);
    op(OP_READ, ta, 8'h00, 1'b0, st);
    chk("other sector", ref_rd(ta), st[15:8]);
    op(OP_IDENT, 17'h04000, 8'h00, 1'b0, st);
    chk("ident suspended", MAKER, st[15:8]);
    op(OP_RESET, 17'h0, 8'h00, 1'b0, st);
    op(OP_READ, 17'h04010, 8'h00, 1'b0, st);
    chk("back to suspend", 8'h80, st[15:8]);
    rm[32'hB000] = 8'h3C;
    op(OP_PROGRAM, 17'h0B000, 8'h3C, 1'b1, st);
    chk("suspend prog", 8'h3C, st[15:8]);
    op(OP_RESUME, 17'h0, 8'h00, 1'b0, st);
    op(OP_POLL, 17'h04010, 8'h80, 1'b0, st);
    foreach (rm[k]) if (k[16:14] == 3'd1 || k[16:14] == 3'd3) rm[k] = 8'hFF;
    chk("erase poll", ref_rd(17'h04010), st[15:8]);
    op(OP_RESUME, 17'h0, 8'h00, 1'b0, st);
    op(OP_READ, 17'h0B000, 8'h00, 1'b0, st);
    chk("after resume", ref_rd(17'h0B000), st[15:8]);
    op(OP_CHIP_ERASE, 17'h0, 8'h00, 1'b1, st);
    chk("chip erase status", 8'h02, {5'h00, st[2:0]});
    rm.delete();
    op(OP_WRITE, 17'h00123, CMD_RESET, 1'b0, st);
    op(OP_READ, 17'h0B000, 8'h00, 1'b0, st);
    chk("chip erased", ref_rd(17'h0B000), st[15:8]);
    op(OP_PROGRAM, 17'h0B000, 8'h00, 1'b1, st);
    op(OP_PROGRAM, 17'h0B000, 8'h80, 1'b1, st);
    chk("prog fail status", 8'h06, {5'h00, st[2:0]});
    op(OP_READ, 17'h0B000, 8'h00, 1'b0, st);
    chk("read after fail", 8'h00, st[15:8]);
    op(4'hC, 17'h0, 8'h00, 1'b0, st);
    chk("bad op", 8'h06, {5'h00, st[2:0]});
    apb(1'b1, REG_STAT, 32'h6, st, e);
    apb(1'b0, REG_STAT, 32'h0, st, e);
    chk("stat cleared", 8'h00, {5'h00, st[2:0]});
    close_out();
  end
endmodule
